// [scs_sequencer.sv]
// Scan-port configuration sequencer top level
// How it works
// - After flash loader writes memory, no self-reconfig; host sends pulse instruction.
// - Reconfig resets master, drops flash loader bridge, memory loads chain.
// - I/O chain instruction accepted only once the settle wait is over and the reconfig pin is high.
// - I/O chain instruction does not hold config status low.
// - User I/Os tri-stated while I/O chain instruction runs.
// - Park before I/O chain when scan programming follows; the selected active controller parks.
// - Resume re-engages parked controller and triggers reconfiguration itself.
// - Park has no effect in passive schemes.
// - Successful scan programming to user mode re-engages parked controller.
// - Serial active: re-engage on test reset state or resume.
// - Parallel active: re-engage only on resume or scan user mode; test reset and reconfig pin do not.
// - Passive schemes: resume behaves like pulse instruction.
`timescale 1ns/10ps
module scs_sequencer (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Scan port
  input wire scs_pkg::scs_instr_t instr_i,
  input wire logic instr_valid_i,
  input wire logic tap_reset_i,
  input wire logic io_chain_busy_i,
  // Configuration pins
  input wire logic reconfig_request_n_i,
  input wire scs_pkg::scs_scheme_t scheme_select_pins_i,
  input wire logic load_done_i,
  input wire logic scan_user_mode_i,
  // Outputs
  output logic device_reset_o,
  output logic bridge_clear_o,
  output logic config_start_o,
  output logic config_status_n_o,
  output logic user_io_hiz_o,
  output logic io_chain_load_o,
  output logic user_mode_o,
  output logic serial_parked_o,
  output logic parallel_parked_o,
  output logic io_chain_ready_o
);
  import scs_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic recfg_n_d;
    logic [SCS_CNT_W-1:0] low_cnt;
    logic [SCS_CNT_W-1:0] wait_cnt;
    logic powered;
    logic trig;
    logic io_load;
    logic status_n;
    logic user;
    logic tap_d;
  } scs_top_state_t;

  scs_top_state_t cur;
  scs_top_state_t next_cur;

  function automatic logic scs_is_active(input scs_scheme_t s);
    return (s == SCS_SERIAL_ACTIVE) || (s == SCS_PARALLEL_ACTIVE);
  endfunction

  function automatic logic scs_instr_is(input scs_instr_t code, input logic vld, input scs_instr_t want);
    return vld && (code == want);
  endfunction

  logic pulse_cmd;
  logic resume_cmd;
  logic park_cmd;
  logic io_cmd;
  logic pin_rise;
  logic pin_recfg;
  logic reconfig;
  logic active;
  logic tap_enter;
  logic s_loading;
  logic p_loading;

  always_comb begin
    active = scs_is_active(scheme_select_pins_i);
    pulse_cmd = scs_instr_is(instr_i, instr_valid_i, SCS_INSTR_PULSE_RECFG);
    resume_cmd = scs_instr_is(instr_i, instr_valid_i, SCS_INSTR_RESUME);
    park_cmd = scs_instr_is(instr_i, instr_valid_i, SCS_INSTR_PARK) && active;
    io_cmd = scs_instr_is(instr_i, instr_valid_i, SCS_INSTR_IO_CHAIN);
    pin_rise = reconfig_request_n_i && !cur.recfg_n_d;
    // Short glitches on the pin are filtered by the minimum low time
    pin_recfg = pin_rise && (cur.low_cnt >= SCS_CNT_W'(SCS_RECFG_LOW_CYC));
    tap_enter = tap_reset_i && !cur.tap_d;
    // Resume always reconfigures; in passive schemes it is the pulse instruction
    reconfig = pulse_cmd || resume_cmd || pin_recfg;
  end

  always_comb begin
    next_cur = cur;
    next_cur.recfg_n_d = reconfig_request_n_i;
    next_cur.tap_d = tap_reset_i;
    next_cur.trig = reconfig;
    if (!reconfig_request_n_i) begin
      if (cur.low_cnt != {SCS_CNT_W{1'b1}}) begin
        next_cur.low_cnt = cur.low_cnt + SCS_CNT_W'(1);
      end
    end else begin
      next_cur.low_cnt = '0;
    end
    if (reconfig || pin_rise || !reconfig_request_n_i) begin
      next_cur.wait_cnt = SCS_CNT_W'(SCS_IO_WAIT_CYC);
    end else if (cur.wait_cnt != '0) begin
      next_cur.wait_cnt = cur.wait_cnt - SCS_CNT_W'(1);
    end
    if (cur.wait_cnt == SCS_CNT_W'(1)) begin
      next_cur.powered = 1'b1;
    end
    if (reconfig) begin
      next_cur.status_n = 1'b0;
      next_cur.user = 1'b0;
    end else if (load_done_i || scan_user_mode_i) begin
      next_cur.status_n = 1'b1;
      next_cur.user = 1'b1;
    end else if (next_cur.powered) begin
      // Rises with the wait flag, so a first I/O chain load never sees status move
      next_cur.status_n = 1'b1;
    end
    // I/O chain load does not touch status, so no hold-low until reconfig
    if (io_cmd && io_chain_ready_o) begin
      next_cur.io_load = 1'b1;
    end else if (!io_chain_busy_i) begin
      next_cur.io_load = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '{recfg_n_d: 1'b1, low_cnt: '0, wait_cnt: SCS_CNT_W'(SCS_IO_WAIT_CYC), powered: 1'b0,
               trig: 1'b0, io_load: 1'b0, status_n: 1'b0, user: 1'b0, tap_d: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // Active controllers
  // ----------------------------------------
  scs_active_ctrl u_serial (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .enable_i(scheme_select_pins_i == SCS_SERIAL_ACTIVE),
    .park_i(park_cmd),
    .engage_i(resume_cmd || tap_enter),
    .start_i(reconfig),
    .load_done_i(load_done_i),
    .user_mode_i(scan_user_mode_i),
    .parked_o(serial_parked_o),
    .loading_o(s_loading)
  );

  scs_active_ctrl u_parallel (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .enable_i(scheme_select_pins_i == SCS_PARALLEL_ACTIVE),
    .park_i(park_cmd),
    .engage_i(resume_cmd),
    .start_i(reconfig),
    .load_done_i(load_done_i),
    .user_mode_i(scan_user_mode_i),
    .parked_o(parallel_parked_o),
    .loading_o(p_loading)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign device_reset_o = cur.trig;
  assign bridge_clear_o = cur.trig;
  assign config_start_o = cur.trig && !(s_loading && p_loading);
  assign config_status_n_o = cur.status_n;
  // A refused I/O chain instruction is not executed, so it leaves the pins alone
  assign user_io_hiz_o = cur.io_load || (io_cmd && io_chain_ready_o);
  assign io_chain_load_o = cur.io_load;
  assign user_mode_o = cur.user;
  // Ready only once power-up wait is done and the pin is high
  assign io_chain_ready_o = cur.powered && reconfig_request_n_i && (cur.wait_cnt == '0);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  status_free_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    io_cmd && io_chain_ready_o && !reconfig |=> cur.status_n == $past(cur.status_n))
    else $error("io chain instruction changed config status");
  hiz_during_io_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    io_chain_load_o |-> user_io_hiz_o)
    else $error("user io not tristated during io chain load");
  passive_park_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !active && !serial_parked_o && !parallel_parked_o |=> !serial_parked_o && !parallel_parked_o)
    else $error("park took effect in passive scheme");
  resume_trig_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    resume_cmd |=> device_reset_o)
    else $error("resume did not trigger reconfiguration");
  no_self_reconfig_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !pulse_cmd && !resume_cmd && !pin_recfg |=> !device_reset_o)
    else $error("reconfiguration started by itself");
  parallel_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    parallel_parked_o && !resume_cmd && !scan_user_mode_i |=> parallel_parked_o)
    else $error("parallel controller re-engaged without resume");
  serial_tap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    serial_parked_o && tap_enter |=> !serial_parked_o)
    else $error("serial controller not re-engaged on test reset");
  user_engage_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (serial_parked_o || parallel_parked_o) && scan_user_mode_i |=> !serial_parked_o && !parallel_parked_o)
    else $error("parked controller not re-engaged at user mode");
  io_ready_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(reconfig_request_n_i) |=> !io_chain_ready_o [*8])
    else $error("io chain ready too soon after pin rise");
endmodule

// [scs_pkg.sv]
// Shared constants and types for the scan configuration sequencer
package scs_pkg;
  // ----------------------------------------
  // Scheme select encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    SCS_SERIAL_ACTIVE   = 2'h0,
    SCS_PARALLEL_ACTIVE = 2'h1,
    SCS_SERIAL_PASSIVE  = 2'h2,
    SCS_PARALLEL_PASSIVE = 2'h3
  } scs_scheme_t;

  // ----------------------------------------
  // Scan instruction codes (decoded form)
  // ----------------------------------------
  typedef enum logic [3:0] {
    SCS_INSTR_NONE        = 4'h0,
    SCS_INSTR_PULSE_RECFG = 4'h1,
    SCS_INSTR_IO_CHAIN    = 4'h2,
    SCS_INSTR_PARK        = 4'h3,
    SCS_INSTR_RESUME      = 4'h4,
    SCS_INSTR_PROGRAM     = 4'h5,
    SCS_INSTR_STATUS_CHK  = 4'h6,
    SCS_INSTR_STARTUP     = 4'h7
  } scs_instr_t;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SCS_CLK_PERIOD_NS = 10;
  localparam int SCS_RECFG_LOW_MIN_NS = 500;
  localparam int SCS_RECFG_LOW_CYC = (SCS_RECFG_LOW_MIN_NS + SCS_CLK_PERIOD_NS - 1) / SCS_CLK_PERIOD_NS;
  localparam int SCS_IO_WAIT_US = 230;
  localparam int SCS_IO_WAIT_CYC = (SCS_IO_WAIT_US * 1000 + SCS_CLK_PERIOD_NS - 1) / SCS_CLK_PERIOD_NS;
  localparam int SCS_CNT_W = 16;

  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    SCS_CTL_IDLE = 4'h1,
    SCS_CTL_LOAD = 4'h2,
    SCS_CTL_USER = 4'h4,
    SCS_CTL_PARK = 4'h8
  } scs_ctl_state_t;
endpackage

// [scs_active_ctrl.sv]
// One active configuration controller with park and re-engage
`timescale 1ns/10ps
module scs_active_ctrl (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic park_i,
  input wire logic engage_i,
  input wire logic start_i,
  input wire logic load_done_i,
  input wire logic user_mode_i,
  // Status
  output logic parked_o,
  output logic loading_o
);
  import scs_pkg::*;

  typedef struct packed {
    scs_ctl_state_t st;
  } scs_ac_state_t;

  scs_ac_state_t cur;
  scs_ac_state_t next_cur;

  always_comb begin
    next_cur = cur;
    unique case (cur.st)
      SCS_CTL_IDLE: begin
        if (enable_i && park_i) begin
          next_cur.st = SCS_CTL_PARK;
        end else if (enable_i && start_i) begin
          next_cur.st = SCS_CTL_LOAD;
        end
      end
      SCS_CTL_LOAD: begin
        if (enable_i && park_i) begin
          next_cur.st = SCS_CTL_PARK;
        end else if (load_done_i) begin
          next_cur.st = SCS_CTL_USER;
        end
      end
      SCS_CTL_USER: begin
        if (enable_i && park_i) begin
          next_cur.st = SCS_CTL_PARK;
        end else if (enable_i && start_i) begin
          next_cur.st = SCS_CTL_LOAD;
        end
      end
      SCS_CTL_PARK: begin
        // Parked controller ignores starts so it cannot fight scan programming
        if (user_mode_i) begin
          next_cur.st = SCS_CTL_USER;
        end else if (engage_i) begin
          next_cur.st = SCS_CTL_LOAD;
        end
      end
      default: next_cur.st = SCS_CTL_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '{st: SCS_CTL_IDLE};
    end else begin
      cur <= next_cur;
    end
  end

  assign parked_o = (cur.st == SCS_CTL_PARK);
  assign loading_o = (cur.st == SCS_CTL_LOAD);

  park_holds_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    parked_o && !user_mode_i && !engage_i |=> parked_o)
    else $error("parked controller left park without cause");
endmodule

// [scs_host_model.sv]
// Behavioural scan host that drives the sequencer's scan port and pin
`timescale 1ns/10ps
module scs_host_model (
  // Clock and status
  input wire logic ref_clk_i,
  input wire logic io_chain_ready_i,
  // Scan port and pin
  output scs_pkg::scs_instr_t instr_o,
  output logic instr_valid_o,
  output logic tap_reset_o,
  output logic reconfig_request_n_o
);
  import scs_pkg::*;
  initial begin
    instr_o = SCS_INSTR_NONE;
    instr_valid_o = 1'b0;
    tap_reset_o = 1'b0;
    reconfig_request_n_o = 1'b1;
  end
  // ----------------------------------------
  // Host operations
  // ----------------------------------------
  task automatic issue(input scs_instr_t i);
    @(posedge ref_clk_i);
    instr_o <= i;
    instr_valid_o <= 1'b1;
    @(posedge ref_clk_i);
    instr_o <= SCS_INSTR_NONE;
    instr_valid_o <= 1'b0;
  endtask
  // Waits out the settle window; a bounded loop so a stuck ready cannot hang
  task automatic io_chain(output bit ok);
    int n;
    n = 0;
    while (io_chain_ready_i !== 1'b1 && n < 30000) begin
      @(negedge ref_clk_i);
      n++;
    end
    ok = (n < 30000);
    if (ok) issue(SCS_INSTR_IO_CHAIN);
  endtask
  task automatic pin_pulse(input int cyc);
    @(posedge ref_clk_i);
    reconfig_request_n_o <= 1'b0;
    repeat (cyc) @(posedge ref_clk_i);
    reconfig_request_n_o <= 1'b1;
  endtask
  task automatic tap_pulse();
    @(posedge ref_clk_i);
    tap_reset_o <= 1'b1;
    @(posedge ref_clk_i);
    tap_reset_o <= 1'b0;
  endtask
endmodule

// [scs_sequencer_tb.sv]
// Self-checking bench for the scan configuration sequencer
`timescale 1ns/10ps
module scs_sequencer_tb;
  import scs_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic io_chain_busy_i = 1'b0;
  logic load_done_i = 1'b0;
  logic scan_user_mode_i = 1'b0;
  scs_scheme_t scheme_select_pins_i = SCS_SERIAL_ACTIVE;
  scs_instr_t instr_i;
  logic instr_valid_i, tap_reset_i, reconfig_request_n_i;
  logic device_reset_o, bridge_clear_o, config_start_o, config_status_n_o, user_io_hiz_o;
  logic io_chain_load_o, user_mode_o, serial_parked_o, parallel_parked_o, io_chain_ready_o;
  int n_fail = 0;
  int n_checks = 0;
  logic [2:0] exp_q[$];
  bit ok;
  time t_up;
  always #5 ref_clk_i = ~ref_clk_i;
  scs_sequencer scs_sequencer_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .tap_reset_i(tap_reset_i), .io_chain_busy_i(io_chain_busy_i),
    .reconfig_request_n_i(reconfig_request_n_i), .scheme_select_pins_i(scheme_select_pins_i),
    .load_done_i(load_done_i), .scan_user_mode_i(scan_user_mode_i), .device_reset_o(device_reset_o),
    .bridge_clear_o(bridge_clear_o), .config_start_o(config_start_o),
    .config_status_n_o(config_status_n_o), .user_io_hiz_o(user_io_hiz_o),
    .io_chain_load_o(io_chain_load_o), .user_mode_o(user_mode_o), .serial_parked_o(serial_parked_o),
    .parallel_parked_o(parallel_parked_o), .io_chain_ready_o(io_chain_ready_o));
  scs_host_model scs_host_model_inst (.ref_clk_i(ref_clk_i), .io_chain_ready_i(io_chain_ready_o),
    .instr_o(instr_i), .instr_valid_o(instr_valid_i), .tap_reset_o(tap_reset_i),
    .reconfig_request_n_o(reconfig_request_n_i));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Each reset pulse retires the oldest note: {serial parked, parallel parked, bridge clear}
  always @(negedge ref_clk_i) begin
    if (!rst_i && device_reset_o === 1'b1) begin
      if (exp_q.size() == 0) chk(3'h1, 3'h0, "unexpected reset");
      else chk({serial_parked_o, parallel_parked_o, bridge_clear_o}, exp_q.pop_front(), "reset");
      chk(config_start_o, 1'b1, "start pulse");
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(59));
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_up = $time;
    cycles(1);
    chk({config_status_n_o, io_chain_ready_o}, 3'h0, "power-up");
    scs_host_model_inst.issue(SCS_INSTR_PARK);
    cycles(1);
    chk(serial_parked_o, 1'b1, "park serial");
    @(posedge ref_clk_i);
    io_chain_busy_i <= 1'b1;
    scs_host_model_inst.io_chain(ok);
    if (!ok) begin
      n_fail++;
      report_and_stop();
    end
    cycles(1);
    chk({io_chain_load_o, user_io_hiz_o, config_status_n_o}, 3'h7, "io chain");
    chk((($time - t_up) / SCS_CLK_PERIOD_NS) inside {[SCS_IO_WAIT_CYC:SCS_IO_WAIT_CYC + 4]}, 1'b1, "wait length");
    @(posedge ref_clk_i);
    io_chain_busy_i <= 1'b0;
    cycles(3);
    chk({io_chain_load_o, user_io_hiz_o}, 3'h0, "io chain end");
    scs_host_model_inst.issue(SCS_INSTR_PROGRAM);
    scs_host_model_inst.issue(SCS_INSTR_STATUS_CHK);
    scs_host_model_inst.issue(SCS_INSTR_STARTUP);
    @(posedge ref_clk_i);
    scan_user_mode_i <= 1'b1;
    @(posedge ref_clk_i);
    scan_user_mode_i <= 1'b0;
    cycles(3);
    chk({serial_parked_o, user_mode_o}, 3'h1, "scan done");
    scs_host_model_inst.tap_pulse();
    scs_host_model_inst.issue(SCS_INSTR_PARK);
    scs_host_model_inst.tap_pulse();
    cycles(3);
    chk(serial_parked_o, 1'b0, "tap engage");
    exp_q.push_back(3'h1);
    scs_host_model_inst.issue(SCS_INSTR_PULSE_RECFG);
    cycles(1);
    chk(io_chain_ready_o, 1'b0, "settle window");
    @(posedge ref_clk_i);
    load_done_i <= 1'b1;
    @(posedge ref_clk_i);
    load_done_i <= 1'b0;
    cycles(3);
    chk(user_mode_o, 1'b1, "reloaded");
    @(posedge ref_clk_i);
    scheme_select_pins_i <= SCS_PARALLEL_ACTIVE;
    scs_host_model_inst.issue(SCS_INSTR_PARK);
    scs_host_model_inst.tap_pulse();
    cycles(3);
    chk(parallel_parked_o, 1'b1, "tap no engage");
    exp_q.push_back(3'h3);
    scs_host_model_inst.pin_pulse(50 + $urandom_range(30));
    cycles(5);
    chk(parallel_parked_o, 1'b1, "pin no engage");
    scs_host_model_inst.issue(SCS_INSTR_IO_CHAIN);
    cycles(1);
    chk(io_chain_load_o, 1'b0, "early io chain");
    scs_host_model_inst.pin_pulse($urandom_range(40, 5));
    cycles(60);
    exp_q.push_back(3'h1);
    scs_host_model_inst.issue(SCS_INSTR_RESUME);
    cycles(1);
    chk(parallel_parked_o, 1'b0, "resume");
    for (int s = 2; s < 4; s++) begin
      @(posedge ref_clk_i);
      scheme_select_pins_i <= scs_scheme_t'(2'(s));
      scs_host_model_inst.issue(SCS_INSTR_PARK);
      cycles(1);
      chk({serial_parked_o, parallel_parked_o}, 3'h0, "passive park");
      exp_q.push_back(3'h1);
      scs_host_model_inst.issue(SCS_INSTR_RESUME);
      cycles(3);
    end
    chk(exp_q.size() == 0, 1'b1, "missing reset");
    report_and_stop();
  end
endmodule
